// *** design/option_select_memory_setup.sv ***
// Behaviour
// [RULE1] Memory enable bit 0 gates board RAM
// [RULE2] Presence register follows selected connector
// [RULE3] Presence bits 7-4 return card identifier
// [RULE4] 4MB card enabled by bits 3-0
// [RULE5] Bit0 low MB, bit1 high MB
// [RULE6] Control bit5 low enables split RAM
// [RULE7] Split: 128KB ROM, 256KB above top
// [RULE8] ROM enable: reads ROM, writes RAM
// [RULE9] ROM off: reads RAM, writes ignored
// [RULE10] Software clears bit5 before ROM enable
// [RULE11] Bit3 speed, cleared by power-on reset
// [RULE12] Control bits 2-0 select memory connector
// [RULE13] Adapter bit7 drives channel reset
// [RULE14] Adapter bit3 enables selected setup line
// [RULE15] Adapter bits 2-0 pick connector
// [RULE16] Setup line active only in 0100-0107
// [RULE17] Adapter in setup answers 0100-0107
// [RULE18] Adapter reads return bits 6-4 set
// [RULE19] Memory registers usable only in setup
// [RULE20] Board setup bit7 low enters setup
// [RULE21] Software uses only 8-bit transfers
// [RULE22] Writable fields read back, reserved ignored
`timescale 1ns/1ns
`default_nettype none
`include "option_select_map.svh"
module option_select_memory_setup
    import option_select_pkg::*;
#(
    parameter int CONNECTORS = 8,
    parameter logic [3:0] ID_SLOT1 = `CARD_ID_NONE,
    parameter logic [3:0] ID_SLOT2 = `CARD_ID_NONE
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [3:0] card_id_slot1,
    input wire logic [3:0] card_id_slot2,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [23:0] mem_addr,
    output logic [7:0] io_rdata,
    output logic io_ack,
    output logic board_ram_en,
    output logic [3:0] slot1_mb_en,
    output logic [3:0] slot2_mb_en,
    output logic split_en,
    output logic rom_en,
    output logic fast_mem,
    output logic [23:0] split_base,
    output logic [1:0] mem_route,
    output logic chan_reset,
    output logic [CONNECTORS-1:0] card_setup_line_n
);
    // ==========================================
    // Pin synchronisers for card id straps
    logic [3:0] id1_s1_ff, id1_s2_ff, id2_s1_ff, id2_s2_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            id1_s1_ff <= ID_SLOT1;
            id1_s2_ff <= ID_SLOT1;
            id2_s1_ff <= ID_SLOT2;
            id2_s2_ff <= ID_SLOT2;
        end else begin
            id1_s1_ff <= card_id_slot1;
            id1_s2_ff <= id1_s1_ff;
            id2_s1_ff <= card_id_slot2;
            id2_s2_ff <= id2_s1_ff;
        end
    end

    // ==========================================
    // Registers
    logic [7:0] board_setup_ff;
    logic mem_enable_ff;
    logic [7:0] mem_control_ff;
    logic [7:0] adapter_ff;
    logic [3:0] card_en1_ff, card_en2_ff;
    logic board_in_setup;
    logic [2:0] slot_sel;
    logic hit_setup_win;

    assign board_in_setup = ~board_setup_ff[`BIT_BOARD_SETUP_N]; // [RULE20]
    assign slot_sel = mem_control_ff[2:0];
    assign hit_setup_win = (io_addr >= `ADDR_SETUP_LO) && (io_addr <= `ADDR_SETUP_HI);

    always_ff @(posedge clk) begin
        if (rst) begin
            board_setup_ff <= `RST_BOARD_SETUP;
        end else if (io_wr && io_addr == `ADDR_BOARD_SETUP) begin
            board_setup_ff <= io_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            adapter_ff <= `RST_ADAPTER;
        end else if (io_wr && io_addr == `ADDR_ADAPTER_SETUP) begin
            adapter_ff <= io_wdata & ~`ADAPTER_RSVD_ONES;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_enable_ff <= `RST_MEM_ENABLE;
        end else if (io_wr && io_addr == `ADDR_MEM_ENABLE && board_in_setup) begin // [RULE19]
            mem_enable_ff <= io_wdata[`BIT_MEM_ENABLE]; // [RULE1] [RULE22]
        end
    end

    // Speed bit is cleared here; ROM starts enabled since ROM is live at power-on
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_control_ff <= `RST_MEM_CONTROL; // [RULE11]
        end else if (io_wr && io_addr == `ADDR_MEM_CONTROL && board_in_setup) begin // [RULE19]
            mem_control_ff <= io_wdata & `MEM_CONTROL_MASK; // [RULE22]
        end
    end

    // Per-connector enables, chosen by the select field
    function automatic logic [3:0] mask_enable(input logic [3:0] id, input logic [3:0] d);
        card_size_t sz;
        sz = card_is_none;
        case (id)
            4'h0: sz = card_is_4mb;
            4'h1, 4'h4, 4'hD: sz = card_is_2mb;
            4'h2, 4'h6, 4'hE: sz = card_is_1mb;
            default: sz = card_is_none;
        endcase
        case (sz)
            card_is_4mb: mask_enable = d; // [RULE4]
            card_is_2mb: mask_enable = {2'h0, d[1:0]}; // [RULE5]
            card_is_1mb: mask_enable = {3'h0, d[0]}; // [RULE5]
            default: mask_enable = 4'h0;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            card_en1_ff <= `RST_CARD_ENABLE;
            card_en2_ff <= `RST_CARD_ENABLE;
        end else if (io_wr && io_addr == `ADDR_MEM_PRESENCE && board_in_setup) begin // [RULE19]
            if (slot_sel == 3'h0) begin // [RULE12] [RULE2]
                card_en1_ff <= mask_enable(id1_s2_ff, io_wdata[3:0]);
            end else if (slot_sel == 3'h1) begin
                card_en2_ff <= mask_enable(id2_s2_ff, io_wdata[3:0]);
            end
        end
    end

    // ==========================================
    // Read path
    logic [7:0] nxt_rdata;
    logic nxt_ack;
    always_comb begin
        nxt_rdata = 8'h00;
        nxt_ack = 1'b0;
        case (io_addr)
            `ADDR_BOARD_SETUP: begin
                nxt_rdata = board_setup_ff;
                nxt_ack = 1'b1;
            end
            `ADDR_ADAPTER_SETUP: begin
                nxt_rdata = adapter_ff | `ADAPTER_RSVD_ONES; // [RULE18]
                nxt_ack = 1'b1;
            end
            `ADDR_MEM_ENABLE: begin
                nxt_rdata = {7'h00, mem_enable_ff};
                nxt_ack = board_in_setup; // [RULE19]
            end
            `ADDR_MEM_PRESENCE: begin
                nxt_ack = board_in_setup;
                case (slot_sel) // [RULE2] [RULE12]
                    3'h0: nxt_rdata = {id1_s2_ff, card_en1_ff}; // [RULE3]
                    3'h1: nxt_rdata = {id2_s2_ff, card_en2_ff}; // [RULE3]
                    default: nxt_rdata = {`CARD_ID_NONE, 4'h0};
                endcase
            end
            `ADDR_MEM_CONTROL: begin
                nxt_rdata = mem_control_ff;
                nxt_ack = board_in_setup;
            end
            default: begin
                nxt_rdata = 8'h00;
                nxt_ack = 1'b0;
            end
        endcase
        // Locked registers read as zero so nothing leaks outside setup
        if (!io_rd || !nxt_ack) begin // [RULE19]
            nxt_rdata = 8'h00;
            nxt_ack = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata <= 8'h00;
            io_ack <= 1'b0;
        end else begin
            io_rdata <= nxt_rdata;
            io_ack <= nxt_ack;
        end
    end

    // ==========================================
    // Memory configuration outputs
    logic [4:0] full_mb;
    always_comb begin
        full_mb = 5'h0;
        for (int i = 0; i < 4; i++) begin
            full_mb = full_mb + 5'(card_en1_ff[i]) + 5'(card_en2_ff[i]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            board_ram_en <= 1'b0;
            slot1_mb_en <= 4'h0;
            slot2_mb_en <= 4'h0;
            split_en <= 1'b0;
            rom_en <= 1'b1;
            fast_mem <= 1'b0;
            split_base <= 24'h0;
        end else begin
            board_ram_en <= mem_enable_ff; // [RULE1]
            slot1_mb_en <= mem_enable_ff ? card_en1_ff : 4'h0;
            slot2_mb_en <= mem_enable_ff ? card_en2_ff : 4'h0;
            split_en <= ~mem_control_ff[`BIT_SPLIT_DISABLE]; // [RULE6]
            rom_en <= mem_control_ff[`BIT_ROM_ENABLE];
            fast_mem <= mem_control_ff[`BIT_FAST_MEM]; // [RULE11]
            // The block sits above the top, after every enabled card MB counted in full_mb
            split_base <= 24'(full_mb) << `MB_SHIFT; // [RULE7]
        end
    end

    // Decoding of the top 128KB below 1MB
    logic in_rom_win;
    assign in_rom_win = (mem_addr >= `ROM_LO) && (mem_addr <= `ROM_HI);
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_route <= route_none;
        end else if (!(mem_rd || mem_wr)) begin
            mem_route <= route_none;
        end else if (!in_rom_win) begin
            mem_route <= route_ram;
        end else if (mem_control_ff[`BIT_ROM_ENABLE]) begin
            mem_route <= mem_rd ? route_rom : route_ram; // [RULE8]
        end else begin
            mem_route <= mem_rd ? route_ram : route_none; // [RULE9]
        end
    end

    // ==========================================
    // Adapter setup
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_reset <= 1'b0;
        end else begin
            chan_reset <= adapter_ff[`BIT_CHAN_RESET]; // [RULE13]
        end
    end

    // Code n-1 picks connector n; window qualifies so the card answers only 0100-0107
    card_setup_decoder #(
        .N(CONNECTORS)
    ) u_setup (
        .clk(clk),
        .rst(rst),
        .enable(adapter_ff[`BIT_SETUP_ENABLE]), // [RULE14]
        .sel(adapter_ff[2:0]), // [RULE15]
        .window_hit(hit_setup_win && (io_rd || io_wr)), // [RULE16] [RULE17]
        .card_setup_line_n(card_setup_line_n)
    );

    // ==========================================
    // Checks
    chk_setup_window: assert property (@(posedge clk) disable iff (rst) // [RULE16]
        !((io_rd || io_wr) && hit_setup_win) |=> &card_setup_line_n)
        else $error("setup line active outside window");
    chk_setup_select: assert property (@(posedge clk) disable iff (rst) // [RULE14] [RULE15]
        ((io_rd || io_wr) && hit_setup_win && adapter_ff[3]) |=>
        !card_setup_line_n[$past(adapter_ff[2:0])])
        else $error("selected setup line not driven");
    chk_adapter_ones: assert property (@(posedge clk) disable iff (rst) // [RULE18]
        (io_rd && io_addr == `ADDR_ADAPTER_SETUP) |=> io_rdata[6:4] == 3'h7)
        else $error("adapter reserved bits not ones");
    chk_rom_read: assert property (@(posedge clk) disable iff (rst) // [RULE8]
        (mem_rd && in_rom_win && mem_control_ff[4]) |=> mem_route == route_rom)
        else $error("rom read misrouted");
    chk_rom_off_wr: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        (mem_wr && !mem_rd && in_rom_win && !mem_control_ff[4]) |=> mem_route == route_none)
        else $error("write not ignored");
    chk_locked_regs: assert property (@(posedge clk) disable iff (rst) // [RULE19]
        (io_wr && io_addr == `ADDR_MEM_CONTROL && !board_in_setup) |=> $stable(mem_control_ff))
        else $error("control written outside setup");
    chk_chan_reset: assert property (@(posedge clk) disable iff (rst) // [RULE13]
        adapter_ff[7] |=> chan_reset)
        else $error("channel reset not driven");
    chk_ram_enable: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        ##1 board_ram_en == $past(mem_enable_ff))
        else $error("board ram enable wrong");
    chk_split_bit: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        mem_control_ff[5] |=> !split_en)
        else $error("split not disabled");
    chk_presence_id: assert property (@(posedge clk) disable iff (rst) // [RULE3] [RULE2]
        (io_rd && board_in_setup && io_addr == `ADDR_MEM_PRESENCE && slot_sel == 3'h0)
        |=> io_rdata[7:4] == $past(id1_s2_ff))
        else $error("presence id wrong");
    chk_speed_reset: assert property (@(posedge clk) $past(rst) |-> !fast_mem) // [RULE11]
        else $error("speed not cleared");
    chk_rom_write: assert property (@(posedge clk) disable iff (rst) // [RULE8]
        (mem_wr && !mem_rd && in_rom_win && mem_control_ff[4]) |=> mem_route == route_ram)
        else $error("rom range write not sent to ram");
    chk_rom_off_read: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        (mem_rd && in_rom_win && !mem_control_ff[4]) |=> mem_route == route_ram)
        else $error("rom range read not sent to ram");
    chk_speed_follow: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        ##1 fast_mem == $past(mem_control_ff[3]))
        else $error("speed output wrong");
    chk_setup_disabled: assert property (@(posedge clk) disable iff (rst) // [RULE14]
        !adapter_ff[3] |=> &card_setup_line_n)
        else $error("setup line active while disabled");
    chk_one_line: assert property (@(posedge clk) disable iff (rst) // [RULE15]
        $countones(~card_setup_line_n) <= 1)
        else $error("more than one setup line active");
    chk_ram_gate: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        !mem_enable_ff |=> (slot1_mb_en == 4'h0) && (slot2_mb_en == 4'h0))
        else $error("card ram enabled while board ram off");
    chk_enable_locked: assert property (@(posedge clk) disable iff (rst) // [RULE19]
        (io_wr && io_addr == `ADDR_MEM_ENABLE && !board_in_setup) |=> $stable(mem_enable_ff))
        else $error("enable written outside setup");
    chk_presence_locked: assert property (@(posedge clk) disable iff (rst) // [RULE19]
        (io_wr && io_addr == `ADDR_MEM_PRESENCE && !board_in_setup) |=>
        $stable(card_en1_ff) && $stable(card_en2_ff))
        else $error("presence written outside setup");
    chk_read_locked: assert property (@(posedge clk) disable iff (rst) // [RULE19]
        (io_rd && !board_in_setup && io_addr >= `ADDR_MEM_ENABLE &&
        io_addr <= `ADDR_MEM_CONTROL) |=> !io_ack && io_rdata == 8'h00)
        else $error("locked register readable outside setup");
    chk_size_mask: assert property (@(posedge clk) disable iff (rst) // [RULE5]
        (io_wr && io_addr == `ADDR_MEM_PRESENCE && board_in_setup && slot_sel == 3'h1 &&
        id2_s2_ff != 4'h0) |=> card_en2_ff[3:2] == 2'h0)
        else $error("reserved enable bits taken");
    chk_presence_sel2: assert property (@(posedge clk) disable iff (rst) // [RULE2] [RULE3]
        (io_rd && board_in_setup && io_addr == `ADDR_MEM_PRESENCE && slot_sel == 3'h1)
        |=> io_rdata[7:4] == $past(id2_s2_ff))
        else $error("second connector id wrong");
endmodule // option_select_memory_setup
`default_nettype wire

// *** design/option_select_map.svh ***
`ifndef OPTION_SELECT_MAP_SVH
`define OPTION_SELECT_MAP_SVH

// ==========================================
// I/O addresses
`define ADDR_BOARD_SETUP 16'h0094
`define ADDR_ADAPTER_SETUP 16'h0096
`define ADDR_MEM_ENABLE 16'h0103
`define ADDR_MEM_PRESENCE 16'h0104
`define ADDR_MEM_CONTROL 16'h0105
`define ADDR_SETUP_LO 16'h0100
`define ADDR_SETUP_HI 16'h0107

// ==========================================
// Field positions
`define BIT_BOARD_SETUP_N 7
`define BIT_MEM_ENABLE 0
`define BIT_SPLIT_DISABLE 5
`define BIT_ROM_ENABLE 4
`define BIT_FAST_MEM 3
`define BIT_CHAN_RESET 7
`define BIT_SETUP_ENABLE 3

// ==========================================
// Reset values and masks
`define RST_BOARD_SETUP 8'hFF
`define RST_MEM_ENABLE 1'h0
`define RST_MEM_CONTROL 8'h10
`define RST_ADAPTER 8'h00
`define RST_CARD_ENABLE 4'h0
`define ADAPTER_RSVD_ONES 8'h70
`define MEM_CONTROL_MASK 8'h3F
`define CARD_ID_NONE 4'hF

// ==========================================
// Memory map
`define ROM_LO 24'h0E0000
`define ROM_HI 24'h0FFFFF
`define MB_SHIFT 20
`define SPLIT_KB_SHIFT 18

`endif

// *** design/option_select_pkg.sv ***
`default_nettype none
package option_select_pkg;
    typedef enum logic [1:0] {
        card_is_4mb,
        card_is_2mb,
        card_is_1mb,
        card_is_none
    } card_size_t;
    typedef enum logic [1:0] {
        route_none,
        route_ram,
        route_rom
    } mem_route_t;
endpackage
`default_nettype wire

// *** design/card_setup_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
module card_setup_decoder #(
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [2:0] sel,
    input wire logic window_hit,
    output logic [N-1:0] card_setup_line_n
);
    // ==========================================
    // Registered so the line is glitch free on the connectors
    always_ff @(posedge clk) begin
        if (rst) begin
            card_setup_line_n <= '1;
        end else begin
            for (int i = 0; i < N; i++) begin
                card_setup_line_n[i] <= ~(enable && window_hit && (sel == 3'(i))); // [RULE14] [RULE16]
            end
        end
    end
endmodule // card_setup_decoder
`default_nettype wire

// *** verification/option_card_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Memory cards and one channel adapter
module option_card_model #(
    parameter logic [3:0] ID1 = 4'h0,
    parameter logic [3:0] ID2 = 4'h1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] card_setup_line_n,
    output logic [3:0] card_id_slot1,
    output logic [3:0] card_id_slot2,
    output logic [7:0] setup_hits
);
    // Id pins are straps, so they never move during a run
    assign card_id_slot1 = ID1;
    assign card_id_slot2 = ID2;
    // Adapter only answers while any of the eight setup lines is low
    always_ff @(posedge clk) begin
        if (rst) begin
            setup_hits <= 8'h00;
        end else if (card_setup_line_n != 8'hFF) begin
            setup_hits <= setup_hits + 8'h01;
        end
    end
endmodule // option_card_model
`default_nettype wire

// *** verification/tb_option_select_memory_setup.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "option_select_map.svh"
module tb_option_select_memory_setup
    import option_select_pkg::*;
;
    logic clk, rst, io_rd, io_wr, mem_rd, mem_wr, board_ram_en, split_en, rom_en, fast_mem;
    logic io_ack, chan_reset, ack;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, card_setup_line_n, rd, ln, setup_hits;
    logic [3:0] card_id_slot1, card_id_slot2, slot1_mb_en, slot2_mb_en;
    logic [23:0] mem_addr, split_base;
    logic [1:0] mem_route;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    // ==========================================
    // Design and far side
    option_select_memory_setup i_dut (.clk(clk), .rst(rst), .io_rd(io_rd), .io_wr(io_wr),
        .io_addr(io_addr), .io_wdata(io_wdata), .card_id_slot1(card_id_slot1),
        .card_id_slot2(card_id_slot2), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .io_rdata(io_rdata), .io_ack(io_ack), .board_ram_en(board_ram_en),
        .slot1_mb_en(slot1_mb_en), .slot2_mb_en(slot2_mb_en), .split_en(split_en),
        .rom_en(rom_en), .fast_mem(fast_mem), .split_base(split_base), .mem_route(mem_route),
        .chan_reset(chan_reset), .card_setup_line_n(card_setup_line_n));
    // Slot 1 holds a 4MB card, slot 2 a 2MB card
    option_card_model #(.ID1(4'h0), .ID2(4'h1)) i_cards (.clk(clk), .rst(rst),
        .card_setup_line_n(card_setup_line_n), .card_id_slot1(card_id_slot1),
        .card_id_slot2(card_id_slot2), .setup_hits(setup_hits));
    // ==========================================
    // Shared tasks
    always #50 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Inputs move at the falling edge so the rising edge never races them
    // One byte per access, never a wide transfer
    task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        io_wr = wr;
        io_rd = ~wr;
        io_addr = a;
        io_wdata = d;
        @(negedge clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
        rd = io_rdata;
        ack = io_ack;
        ln = card_setup_line_n;
    endtask
    task automatic mem(input logic wr, input logic [23:0] a, input logic [1:0] e);
        @(negedge clk);
        mem_wr = wr;
        mem_rd = ~wr;
        mem_addr = a;
        @(negedge clk);
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        chk("mem_route", {30'h0, e}, {30'h0, mem_route});
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        @(negedge clk);
        chk("ram_en", 0, board_ram_en);
        chk("rom_en", 1, rom_en);
        chk("fast", 0, fast_mem);
        chk("lines", 8'hFF, card_setup_line_n);
        io(1'b1, `ADDR_MEM_CONTROL, 8'h08);
        io(1'b1, `ADDR_MEM_PRESENCE, 8'h0F);
        io(1'b0, `ADDR_MEM_CONTROL, 8'h00);
        chk("ctl out of setup", 9'h000, {rd, ack});
    endtask
    task automatic t_control();
        io(1'b1, `ADDR_BOARD_SETUP, 8'h7F);
        io(1'b0, `ADDR_MEM_CONTROL, 8'h00);
        chk("ctl reset", 8'h10, rd);
        chk("ack", 1, ack);
        io(1'b1, `ADDR_MEM_CONTROL, 8'hC8);
        io(1'b0, `ADDR_MEM_CONTROL, 8'h00);
        chk("ctl", 8'h08, rd);
        chk("fast", 1, fast_mem);
        io(1'b1, `ADDR_MEM_ENABLE, 8'h01);
        io(1'b0, `ADDR_MEM_ENABLE, 8'h00);
        chk("mem_en", 8'h01, rd);
        chk("ram_en", 1, board_ram_en);
    endtask
    task automatic t_presence();
        io(1'b1, `ADDR_MEM_CONTROL, 8'h10);
        io(1'b1, `ADDR_MEM_PRESENCE, 8'h0F);
        io(1'b0, `ADDR_MEM_PRESENCE, 8'h00);
        chk("pres1", 8'h0F, rd);
        chk("slot1", 4'hF, slot1_mb_en);
        io(1'b1, `ADDR_MEM_CONTROL, 8'h11);
        io(1'b1, `ADDR_MEM_PRESENCE, 8'h0F);
        io(1'b0, `ADDR_MEM_PRESENCE, 8'h00);
        chk("pres2", 8'h13, rd);
        chk("slot2", 4'h3, slot2_mb_en);
        chk("slot1 kept", 4'hF, slot1_mb_en);
        chk("split_base", 24'h600000, split_base);
        io(1'b1, `ADDR_MEM_CONTROL, 8'h12);
        io(1'b0, `ADDR_MEM_PRESENCE, 8'h00);
        chk("pres sel rsvd", 8'hF0, rd);
    endtask
    task automatic t_rom();
        io(1'b1, `ADDR_MEM_CONTROL, 8'h10);
        mem(1'b0, `ROM_LO, route_rom);
        mem(1'b1, `ROM_HI, route_ram);
        io(1'b1, `ADDR_MEM_CONTROL, 8'h30);
        io(1'b0, `ADDR_MEM_CONTROL, 8'h00);
        chk("split off", 0, split_en);
        // Split is re-enabled before ROM goes off
        io(1'b1, `ADDR_MEM_CONTROL, 8'h10);
        io(1'b1, `ADDR_MEM_CONTROL, 8'h00);
        io(1'b0, `ADDR_MEM_CONTROL, 8'h00);
        chk("split on", 1, split_en);
        chk("rom off", 0, rom_en);
        mem(1'b0, `ROM_HI, route_ram);
        mem(1'b1, `ROM_LO, route_none);
        io(1'b1, `ADDR_MEM_ENABLE, 8'h00);
        @(negedge clk);
        chk("slot1 masked", 4'h0, slot1_mb_en);
        io(1'b1, `ADDR_BOARD_SETUP, 8'hFF);
        io(1'b0, `ADDR_MEM_CONTROL, 8'h00);
        chk("left setup", 0, {rd, ack});
    endtask
    task automatic t_adapter();
        io(1'b1, `ADDR_ADAPTER_SETUP, 8'h8A);
        @(negedge clk);
        chk("chan_reset", 1, chan_reset);
        io(1'b0, `ADDR_ADAPTER_SETUP, 8'h00);
        chk("adapter rd", 8'hFA, rd);
        io(1'b1, `ADDR_ADAPTER_SETUP, 8'h02);
        io(1'b0, `ADDR_SETUP_LO, 8'h00);
        chk("setup off", 8'hFF, ln);
        for (int n = 0; n < 8; n++) begin
            io(1'b1, `ADDR_ADAPTER_SETUP, 8'h08 | n[7:0]);
            io(n[0], `ADDR_SETUP_LO + n[15:0], 8'h00);
            chk("line", 8'(~(8'h01 << n)), ln);
        end
        io(1'b0, `ADDR_SETUP_HI + 16'h0001, 8'h00);
        chk("outside", 8'hFF, ln);
        chk("hits", 8, setup_hits);
        io(1'b1, `ADDR_ADAPTER_SETUP, 8'h00);
    endtask
    // ==========================================
    // Main sequence and hang guard
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_addr = 24'h000000;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_control();
        t_presence();
        t_rom();
        t_adapter();
        results();
    end
    // Whole run needs about 120 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end
endmodule // tb_option_select_memory_setup
`default_nettype wire
